//--- pkg/sac_pkg.sv
// Purpose: Constants for the eight-channel successive-approximation converter control
// Assumes: Byte-wide register port, one core clock
// Notes: Offsets are byte addresses on the register port
package sac_pkg;
    localparam int ADDR_W = 16;
    localparam logic [15:0] MODE_OFS = 16'hffc4;
    localparam logic [15:0] RESULT_OFS = 16'hffc5;
    localparam logic [15:0] START_OFS = 16'hffc6;
    localparam logic [7:0] MODE_RESET = 8'h30;
    localparam logic [7:0] START_RESET = 8'h7f;
    localparam logic [7:0] UNMAPPED_READ = 8'hff;
    localparam int SPEED_BIT = 7;
    localparam int TRIG_EN_BIT = 6;
    localparam int ACTIVE_BIT = 7;
    localparam logic [1:0] MODE_FIXED_ONES = 2'h3;
    localparam logic [6:0] START_FIXED_ONES = 7'h7f;
    localparam logic [6:0] SLOW_PERIOD = 7'h3e;
    localparam logic [6:0] FAST_PERIOD = 7'h1f;
    localparam logic [6:0] START_COUNT = 7'h01;
    localparam logic [6:0] BIT_FIRST_COUNT = 7'h02;
    localparam logic [6:0] BIT_END_COUNT = 7'h0a;
    localparam logic [7:0] FIRST_TRIAL = 8'h80;
    localparam logic [2:0] LAST_BIT = 3'h0;
    localparam logic [2:0] FIRST_BIT = 3'h7;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_APPROX = 3'b100
    } sac_state_t;
endpackage

//--- src/sac_sync.sv
// Purpose: Two-flop synchroniser for one level
// Assumes: Asynchronous input
// Notes: First stage read only by second
`timescale 1ns/100ps
module sac_sync
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- src/sac_adc_ctrl.sv
// Purpose: Control of an 8-bit successive-approximation converter, eight inputs
// Assumes: Comparator output from the analog ladder, edge select from outside
// Notes: Result register has no reset
`timescale 1ns/100ps
module sac_adc_ctrl
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [sac_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic external_trigger_pin_n,
    input wire logic trigger_edge_select,
    input wire logic comparator_high,
    output logic [7:0] ladder_code,
    output logic sample_hold,
    output logic [7:0] channel_enable,
    output logic end_of_conversion_request
);
    import sac_pkg::*;

    logic [7:0] mode_q;
    logic active_q;
    logic [7:0] result_q;
    logic [7:0] sar_q;
    logic [2:0] bit_idx_q;
    logic [6:0] count_q;
    logic [6:0] period_q;
    logic trig_sync;
    logic trig_prev_q;
    logic trig_edge;
    logic write_start;
    logic write_stop;
    logic start_evt;
    logic done;
    logic launch;
    logic decide;
    logic trig_rise;
    logic trig_fall;
    logic mode_hit;
    logic start_hit;
    logic chan_valid;
    logic [2:0] chan_idx;
    logic [7:0] rdata_d;
    sac_state_t state_q;

    sac_sync u_trig_sync
    (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .async_in(~external_trigger_pin_n),
        .sync_out(trig_sync)
    );

    // Edge detect on synchronised trigger
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            trig_prev_q <= 1'b0;
        end
        else
        begin
            trig_prev_q <= trig_sync;
        end
    end

    // Pin edges, level inverted ahead of the synchroniser
    assign trig_rise = trig_prev_q & ~trig_sync;
    assign trig_fall = ~trig_prev_q & trig_sync;

    // Rising when select is one, falling otherwise
    assign trig_edge = trigger_edge_select ? trig_rise : trig_fall;

    assign mode_hit = (reg_addr == MODE_OFS);
    assign start_hit = (reg_addr == START_OFS);
    assign write_start = reg_write && start_hit && reg_wdata[ACTIVE_BIT];
    assign write_stop = reg_write && start_hit && !reg_wdata[ACTIVE_BIT];
    assign start_evt = write_start || (mode_q[TRIG_EN_BIT] && trig_edge);

    // Mode register, fixed ones in bits 5 and 4
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mode_q <= MODE_RESET;
        end
        else if (reg_write && mode_hit)
        begin
            mode_q <= {reg_wdata[7:6], MODE_FIXED_ONES, reg_wdata[3:0]};
        end
    end

    // Start accepted only from idle, stop wins
    assign launch = (state_q == ST_IDLE) && start_evt && !write_stop;

    // Bit decisions at counts two to nine
    assign decide = (state_q == ST_APPROX) && (count_q >= BIT_FIRST_COUNT)
                    && (count_q < BIT_END_COUNT) && !write_stop;

    assign done = (state_q == ST_APPROX) && (count_q == period_q) && !write_stop;

    // Conversion state
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
        end
        else if (write_stop)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (start_evt)
                    begin
                        state_q <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE:
                begin
                    state_q <= ST_APPROX;
                end
                ST_APPROX:
                begin
                    if (count_q == period_q)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Clocks counted from the start edge
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_q <= 7'h00;
        end
        else if (launch)
        begin
            count_q <= START_COUNT;
        end
        else if (write_stop || (state_q == ST_IDLE))
        begin
            count_q <= 7'h00;
        end
        else
        begin
            count_q <= count_q + 7'h01;
        end
    end

    // Period latched at start
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            period_q <= SLOW_PERIOD;
        end
        else if (launch)
        begin
            period_q <= mode_q[SPEED_BIT] ? FAST_PERIOD : SLOW_PERIOD;
        end
    end

    // Trial code, one bit decided per cycle, msb first
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sar_q <= 8'h00;
        end
        else if (launch)
        begin
            sar_q <= FIRST_TRIAL;
        end
        else if (decide)
        begin
            sar_q[bit_idx_q] <= comparator_high;
            if (bit_idx_q != LAST_BIT)
            begin
                sar_q[bit_idx_q - 3'h1] <= 1'b1;
            end
        end
    end

    // Bit under trial
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bit_idx_q <= FIRST_BIT;
        end
        else if (launch)
        begin
            bit_idx_q <= FIRST_BIT;
        end
        else if (decide && (bit_idx_q != LAST_BIT))
        begin
            bit_idx_q <= bit_idx_q - 3'h1;
        end
    end

    // Active flag
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            active_q <= 1'b0;
        end
        else if (write_stop || done)
        begin
            active_q <= 1'b0;
        end
        else if (launch)
        begin
            active_q <= 1'b1;
        end
    end

    // Result, no reset, loaded only at completion
    always_ff @(posedge core_clk)
    begin
        if (done)
        begin
            result_q <= sar_q;
        end
    end

    // Completion pulse
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            end_of_conversion_request <= 1'b0;
        end
        else
        begin
            end_of_conversion_request <= done;
        end
    end

    // Channel field: 01xx inputs 0 to 3, 10xx inputs 4 to 7, others none
    assign chan_valid = mode_q[3] ^ mode_q[2];
    assign chan_idx = {mode_q[3], mode_q[1:0]};

    // Channel decode
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            channel_enable <= 8'h00;
        end
        else
        begin
            if (chan_valid)
            begin
                channel_enable <= 8'h01 << chan_idx;
            end
            else
            begin
                channel_enable <= 8'h00;
            end
        end
    end

    // Trial code drives the ladder with no lag
    assign ladder_code = sar_q;

    // Sample pulse
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sample_hold <= 1'b0;
        end
        else
        begin
            sample_hold <= (state_q == ST_SAMPLE);
        end
    end

    // Read mux
    always_comb
    begin
        rdata_d = UNMAPPED_READ;
        case (reg_addr)
            MODE_OFS: rdata_d = mode_q;
            RESULT_OFS: rdata_d = result_q;
            START_OFS: rdata_d = {active_q, START_FIXED_ONES};
            default: rdata_d = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reg_rdata <= 8'h00;
        end
        else if (reg_read)
        begin
            reg_rdata <= rdata_d;
        end
        else
        begin
            reg_rdata <= 8'h00;
        end
    end
endmodule

//--- sim/sac_analog_model.sv
// Purpose: Analog inputs and comparator of the converter
// Assumes: Comparator follows the ladder code at once
// Notes: No channel selected compares low
`timescale 1ns/100ps
module sac_analog_model
(
    input wire logic [63:0] levels,
    input wire logic [7:0] ladder_code,
    input wire logic [7:0] channel_enable,
    output logic comparator_high
);
    logic [7:0] lvl;
    always_comb
    begin
        lvl = 8'h00;
        for (int i = 0; i < 8; i++)
            if (channel_enable[i])
                lvl = levels[i * 8 +: 8];
    end
    assign comparator_high = (channel_enable != 8'h00) && (lvl >= ladder_code); // Ideal
endmodule

//--- sim/sac_adc_ctrl_assertions.sv
// Purpose: Port checks for converter control
// Assumes: Timing as handed over
// Notes: Bound to the control module
`timescale 1ns/100ps
module sac_adc_ctrl_assertions
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [sac_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic sample_hold,
    input wire logic [7:0] channel_enable,
    input wire logic end_of_conversion_request
);
    import sac_pkg::*;
    logic eoc;
    assign eoc = end_of_conversion_request;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    a_start_ones:
        assert property (reg_read && reg_addr == START_OFS |=> reg_rdata[6:0] == 7'h7f)
        else $error("Start bits wrong");
    a_mode_ones:
        assert property (reg_read && reg_addr == MODE_OFS |=> reg_rdata[5:4] == 2'h3)
        else $error("Mode bits wrong");
    a_rdata_idle:
        assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("Read data not idle");
    a_req_pulse:
        assert property (eoc |=> !eoc)
        else $error("Request too long");
    a_stop_quiet:
        assert property (reg_write && reg_addr == START_OFS && !reg_wdata[7] |-> ##2 !eoc [*8])
        else $error("Request after stop");
    a_sample_pulse:
        assert property (sample_hold |=> !sample_hold)
        else $error("Sample too long");
    a_chan_onehot:
        assert property ($onehot0(channel_enable))
        else $error("Channel not one-hot");
    a_conv_period:
        assert property (eoc |-> $past(sample_hold, 61) || $past(sample_hold, 30))
        else $error("Period wrong");
    c_req: cover property (eoc);
    c_fast: cover property (eoc && $past(sample_hold, 30));
    c_stop: cover property (reg_write && reg_addr == START_OFS && !reg_wdata[7]);
endmodule
bind sac_adc_ctrl sac_adc_ctrl_assertions chk_u (.core_clk, .reset_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .sample_hold, .channel_enable,
    .end_of_conversion_request);

//--- sim/test_sar_adc_control_8ch.sv
// Purpose: Self-checking bench for converter control
// Assumes: Analog model drives the comparator
// Notes: Random levels and channels, fixed seed
`timescale 1ns/100ps
module test_sar_adc_control_8ch;
    import sac_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic pin_n = 1'b1;
    logic edge_sel = 1'b0;
    logic [63:0] levels = '0;
    logic [7:0] reg_rdata, ladder_code, channel_enable, v, m;
    logic comparator_high, sample_hold, eoc;
    int n_mismatch = 0;
    int num_checks = 0;
    int cnt;
    always #2 core_clk = ~core_clk;
    sac_adc_ctrl dut_u (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .external_trigger_pin_n(pin_n), .trigger_edge_select(edge_sel),
        .comparator_high, .ladder_code, .sample_hold, .channel_enable,
        .end_of_conversion_request(eoc));
    sac_analog_model ana_u (.levels, .ladder_code, .channel_enable, .comparator_high);
    function automatic logic [7:0] chan_exp(input logic [3:0] c);
        return (c[3] ^ c[2]) ? 8'h01 << (c - 4'h4) : 8'h00;
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [15:0] a);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(negedge core_clk);
        v = reg_rdata;
        @(posedge core_clk);
    endtask
    task automatic run(input logic [7:0] mode, input logic sw);
        if (sw)
        begin
            wr(MODE_OFS, mode);
            wr(START_OFS, 8'h80);
        end
        cnt = 1;
        @(negedge core_clk);
        while (eoc !== 1'b1 && cnt < 100)
        begin
            @(negedge core_clk);
            cnt++;
        end
        @(posedge core_clk);
        if (cnt >= 100)
        begin
            n_mismatch++;
            stop_test();
        end
        if (sw)
            chk(8'(cnt), mode[7] ? {1'b0, FAST_PERIOD} : {1'b0, SLOW_PERIOD});
        rd(START_OFS);
        chk(v, 8'h7f);
        rd(RESULT_OFS);
        chk(v, levels[(mode[3:0] - 4) * 8 +: 8]);
    endtask
    initial
    begin
        void'($urandom(17756));
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(MODE_OFS);
        chk(v, 8'h30);
        wr(START_OFS, 8'h00);
        rd(START_OFS);
        chk(v, 8'h7f);
        rd(16'hffc7);
        chk(v, UNMAPPED_READ);
        $display("reset test done");
        for (int c = 0; c < 16; c++)
        begin
            m = {1'($urandom), 3'h0, 4'(c)};
            wr(MODE_OFS, m);
            @(negedge core_clk);
            chk(channel_enable, chan_exp(4'(c)));
            @(posedge core_clk);
            rd(MODE_OFS);
            chk(v, m | 8'h30);
        end
        $display("mode test done");
        levels <= {8'hff, 8'h00, 16'($urandom), $urandom};
        run(8'h0b, 1'b1);
        run(8'h8a, 1'b1);
        for (int i = 0; i < 6; i++)
            run({1'(i % 2), 3'h0, 4'($urandom_range(11, 4))}, 1'b1);
        $display("conversion test done");
        rd(RESULT_OFS);
        m = v;
        wr(RESULT_OFS, ~m);
        wr(START_OFS, 8'h80);
        rd(START_OFS);
        chk(v, 8'hff);
        wr(START_OFS, 8'h00);
        rd(START_OFS);
        chk(v, 8'h7f);
        repeat (80)
        begin
            @(negedge core_clk);
            chk({7'h0, eoc}, 8'h00);
        end
        @(posedge core_clk);
        rd(RESULT_OFS);
        chk(v, m);
        $display("stop test done");
        for (int e = 0; e < 2; e++)
        begin
            wr(MODE_OFS, 8'h05);
            edge_sel <= 1'(e);
            pin_n <= ~1'(e);
            repeat (8) @(posedge core_clk);
            pin_n <= 1'(e);
            repeat (8) @(posedge core_clk);
            rd(START_OFS);
            chk(v, 8'h7f);
            wr(MODE_OFS, 8'h45);
            pin_n <= ~1'(e);
            repeat (8) @(posedge core_clk);
            rd(START_OFS);
            chk(v, 8'h7f);
            pin_n <= 1'(e);
            repeat (8) @(posedge core_clk);
            rd(START_OFS);
            chk(v, 8'hff);
            run(8'h45, 1'b0);
        end
        $display("trigger test done");
        stop_test();
    end
endmodule
